// ### inc/uilc_defines.svh
`ifndef UILC_DEFINES_SVH
`define UILC_DEFINES_SVH

`define UILC_CTRL_PORT     16'h00e5
`define UILC_CTRL_RESET    8'h00
`define UILC_LED1_AMBER    2
`define UILC_LED1_GREEN    3
`define UILC_LED0_AMBER    0
`define UILC_LED0_GREEN    1
`define UILC_LED1_MASK     8'hf3
`define UILC_LAMP_LSB      0
`define UILC_LAMP_MSB      3
`define UILC_SPARE_LSB     4
`define UILC_SPARE_MSB     7
`define UILC_LAMP_RESET    4'h0
`define UILC_SPARE_RESET   4'h0
`define UILC_RDATA_IDLE    8'h00

`endif

// ### inc/uilc_pkg.sv
`default_nettype none
package uilc_pkg;
	typedef logic [7:0]  uilc_byte_t;
	typedef logic [15:0] uilc_addr_t;
	typedef logic [1:0]  uilc_pair_t;
endpackage : uilc_pkg
`default_nettype wire

// ### hdl/uilc_lamp_drive.sv
`timescale 1ns/10ps
`default_nettype none
`include "uilc_defines.svh"
module uilc_lamp_drive
	import uilc_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire uilc_pair_t pairBits,
	input  wire logic       amberIdx,
	output logic            amberOn,
	output logic            greenOn
);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			amberOn <= 1'b0;
			greenOn <= 1'b0;
		end else begin
			amberOn <= amberIdx ? pairBits[1] : pairBits[0];
			greenOn <= amberIdx ? pairBits[0] : pairBits[1];
		end
	end
endmodule : uilc_lamp_drive
`default_nettype wire

// ### hdl/uilc_led_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "uilc_defines.svh"

module uilc_led_ctrl
	import uilc_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,

	// Port access from the host
	input  wire uilc_addr_t ioAddr,
	input  wire logic       ioWr,
	input  wire logic       ioRd,
	input  wire uilc_byte_t ioWdata,
	output uilc_byte_t      ioRdata,
	output logic            ioHit,

	// Light drives, active high
	output logic            led0Amber,
	output logic            led0Green,
	output logic            led1Amber,
	output logic            led1Green
);

	// Light bits of the held byte
	logic [3:0] lamp_r;
	logic [3:0] lamp_nxt;

	// Bits of the other functions, only held and read back
	logic [3:0] spare_r;
	logic [3:0] spare_nxt;

	// Whole held byte, and the byte after a possible write
	uilc_byte_t ctrlByte;
	uilc_byte_t ctrlWrite;

	// Read data register and its next value
	uilc_byte_t rdata_r;
	uilc_byte_t rdata_nxt;

	// Strobes qualified by the port decode
	logic       wrHit;
	logic       rdHit;

	// Pair of each light, amber element in bit 0
	uilc_pair_t led0Pair;
	uilc_pair_t led1Pair;

	function automatic logic portHit(
		input uilc_addr_t a
	);
		portHit = (a == `UILC_CTRL_PORT);
	endfunction : portHit

	// Shared by both strobes so read and write decode alike
	function automatic logic accessHit(
		input uilc_addr_t a,
		input logic       strobe
	);
		accessHit = portHit(a) & strobe;
	endfunction : accessHit

	// pair of one light, amber first
	function automatic uilc_pair_t lampPair(
		input uilc_byte_t b,
		input logic       upper
	);
		uilc_pair_t p;
		p = 2'b00;
		case (upper)
			1'b0: begin
				p[0] = b[`UILC_LED0_AMBER];
				p[1] = b[`UILC_LED0_GREEN];
			end
			1'b1: begin
				p[0] = b[`UILC_LED1_AMBER];
				p[1] = b[`UILC_LED1_GREEN];
			end
			default: begin
				p = 2'b00;
			end
		endcase
		lampPair = p;
	endfunction : lampPair

	// whole byte taken on a write
	function automatic uilc_byte_t ctrlNext(
		input uilc_byte_t cur,
		input logic       hit,
		input uilc_byte_t data
	);
		uilc_byte_t n;
		n = cur;
		if (hit) begin
			n = data;
		end
		ctrlNext = n;
	endfunction : ctrlNext

	// held byte on a read, idle value otherwise
	function automatic uilc_byte_t rdataNext(
		input uilc_byte_t cur,
		input logic       hit
	);
		uilc_byte_t n;
		n = `UILC_RDATA_IDLE;
		if (hit) begin
			n = cur;
		end
		rdataNext = n;
	endfunction : rdataNext

	assign wrHit = accessHit(ioAddr, ioWr);
	assign rdHit = accessHit(ioAddr, ioRd);

	// Combinational so the host sees the claim in the access cycle
	assign ioHit = wrHit | rdHit;

	always_comb begin
		ctrlWrite = ctrlNext(ctrlByte, wrHit, ioWdata);
	end

	always_comb begin
		lamp_nxt = ctrlWrite[`UILC_LAMP_MSB:`UILC_LAMP_LSB];
	end

	// Upper bits held as written, so read-modify-write keeps them
	always_comb begin
		spare_nxt = ctrlWrite[`UILC_SPARE_MSB:`UILC_SPARE_LSB];
	end

	// reset clears light bits, lights dark
	// Async so the lights go dark even while the clock is stopped
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			lamp_r <= `UILC_LAMP_RESET;
		end else begin
			lamp_r <= lamp_nxt;
		end
	end

	// reset clears the other bits too
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			spare_r <= `UILC_SPARE_RESET;
		end else begin
			spare_r <= spare_nxt;
		end
	end

	// Held byte as a read sees it
	assign ctrlByte = {spare_r, lamp_r};

	// readback of held value
	// Idle outside a read so a shared data bus sees no stale byte
	always_comb begin
		rdata_nxt = rdataNext(ctrlByte, rdHit);
	end

	// Read data stands for the one cycle after the read
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata_r <= `UILC_RDATA_IDLE;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign ioRdata = rdata_r;

	// pair of light two, from its own bits only
	always_comb begin
		led0Pair = lampPair(ctrlByte, 1'b0);
	end

	// pair of light one, from its own bits only
	always_comb begin
		led1Pair = lampPair(ctrlByte, 1'b1);
	end

	// light two: bit 0 amber, bit 1 green
	// Lights lag the register by one cycle; fine for a panel lamp
	uilc_lamp_drive u_led0 (
		.mclk     (mclk),
		.rst      (rst),
		.pairBits (led0Pair),
		.amberIdx (1'b0),
		.amberOn  (led0Amber),
		.greenOn  (led0Green)
	);

	// light one: bit 3 green, bit 2 amber
	uilc_lamp_drive u_led1 (
		.mclk     (mclk),
		.rst      (rst),
		.pairBits (led1Pair),
		.amberIdx (1'b0),
		.amberOn  (led1Amber),
		.greenOn  (led1Green)
	);

	// Both lamp drives share one clock and reset, so the lights
	// change together on the same edge after a write; no light can
	// show a mix of old and new settings for a cycle.

	// The four upper bits belong to other functions of the shared
	// register. They are kept here only so that a host doing
	// read-modify-write gets back what it wrote; nothing else reads
	// them inside this block.

	// Pattern 11 on a pair lights both elements of that light at
	// once; the host is expected to use 01, 10 or 00 only.

endmodule : uilc_led_ctrl
`default_nettype wire

// ### bench/uilc_chk.sv
`timescale 1ns/10ps
`default_nettype none
module uilc_chk
	import uilc_pkg::*;
(
	input wire logic       mclk,
	input wire logic       rst,
	input wire uilc_addr_t ioAddr,
	input wire logic       ioWr,
	input wire logic       ioRd,
	input wire uilc_byte_t ioWdata,
	input wire uilc_byte_t ioRdata,
	input wire logic       ioHit,
	input wire logic       led0Amber,
	input wire logic       led0Green,
	input wire logic       led1Amber,
	input wire logic       led1Green
);
logic w;
logic r;
logic [3:0] l;
uilc_byte_t shadow;
assign w=(ioAddr==16'h00e5)&&ioWr;
assign r=(ioAddr==16'h00e5)&&ioRd;
assign l={led1Green,led1Amber,led0Green,led0Amber};
// Byte last written, kept from the bus alone
always_ff @(posedge mclk or posedge rst) if(rst) shadow<=8'h00; else if(w) shadow<=ioWdata;
sequence s_wr; w; endsequence
sequence s_quiet; (!w)[*2]; endsequence
a_leds_follow:assert property(@(posedge mclk)disable iff(rst)s_wr|=>##1 l==$past(ioWdata[3:0],2))else $error("led");
a_leds_hold:assert property(@(posedge mclk)disable iff(rst)s_quiet|=>$stable(l))else $error("hold");
a_reset_dark:assert property(@(posedge mclk)rst|->l==4'h0)else $error("rst");
a_led_map:assert property(@(posedge mclk)disable iff(rst)l==$past(shadow[3:0]))else $error("map");
a_hit_decode:assert property(@(posedge mclk)ioHit==(w||r))else $error("hit");
a_read_back:assert property(@(posedge mclk)disable iff(rst)r|=>ioRdata==$past(shadow))else $error("readback");
a_read_idle:assert property(@(posedge mclk)disable iff(rst)!r|=>ioRdata==8'h00)else $error("idle");
endmodule : uilc_chk
`default_nettype wire

// ### bench/user_indicator_led_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module user_indicator_led_control_bench import uilc_pkg::*;;
logic mclk=0,rst=1,ioWr=0,ioRd=0,ioHit,led0Amber,led0Green,led1Amber,led1Green;
uilc_addr_t ioAddr=16'h00e5;
uilc_byte_t ioWdata=8'h00,ioRdata,q;
int mismatches=0,checks=0,n=0;
wire [3:0] l={led1Green,led1Amber,led0Green,led0Amber};
uilc_led_ctrl i_dut(.mclk(mclk),.rst(rst),.ioAddr(ioAddr),.ioWr(ioWr),.ioRd(ioRd),.ioWdata(ioWdata),
.ioRdata(ioRdata),.ioHit(ioHit),.led0Amber(led0Amber),.led0Green(led0Green),.led1Amber(led1Amber),
.led1Green(led1Green));
initial forever #2 mclk=~mclk;
always @(posedge mclk) if(++n>999) begin mismatches++; results; end
task ck(input uilc_byte_t s,e);
checks++;
if(s!==e) begin mismatches++; $display("wrong value at %0t: seen %h expected %h",$time,s,e); end
endtask : ck
task wr(input uilc_byte_t d,uilc_addr_t a=16'h00e5);
ioAddr=a; ioWr=1; ioWdata=d;
@(negedge mclk) ioWr=0;
endtask : wr
task rd(input uilc_addr_t a=16'h00e5);
ioAddr=a; ioRd=1;
@(posedge mclk) ck({7'h0,ioHit},{7'h0,a==16'h00e5});
@(negedge mclk) ioRd=0; q=ioRdata;
endtask : rd
task t_rst;
rst=1;
@(negedge mclk) ck({4'h0,l},8'h00);
rst=0;
rd();
ck(q,8'h00);
$display("reset end");
endtask : t_rst
task t_pairs;
for(int i=0;i<16;i++) begin
wr(8'ha0|i[7:0]);
rd();
ck(q,8'ha0|i[7:0]);
ck({4'h0,l},i[7:0]);
end
$display("pairs end");
endtask : t_pairs
task t_rmw;
@(negedge mclk) rd();
wr(q&8'hf3|8'h04);
rd();
ck(q,8'ha7);
ck({4'h0,l},8'h07);
wr(8'hff,16'h00e4);
rd(16'h00e4);
ck(q,8'h00);
ck({4'h0,l},8'h07);
$display("rmw end");
endtask : t_rmw
task results;
$display("%0d checks %0d mismatches",checks,mismatches);
if(mismatches==0&&checks>0) $display("ALL CHECKS OK");
else $display("CHECKS NOT OK");
$finish;
endtask : results
initial begin repeat(4) @(negedge mclk); t_rst; t_pairs; t_rmw; t_rst; results; end
endmodule : user_indicator_led_control_bench
bind uilc_led_ctrl uilc_chk i_chk(.mclk(mclk),.rst(rst),.ioAddr(ioAddr),.ioWr(ioWr),.ioRd(ioRd),.ioWdata(ioWdata),
.ioRdata(ioRdata),.ioHit(ioHit),.led0Amber(led0Amber),.led0Green(led0Green),.led1Amber(led1Amber),
.led1Green(led1Green));
`default_nettype wire
